// ==== plt_limit_telemetry.sv ====
// Level-request decoder, limit control and power telemetry with APB access
// -----------------------------------------------------------------------
// -----------------------------------------------------------------------
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
module plt_limit_telemetry #(
  parameter int unsigned PERIOD_CYC = plt_pkg::PERIOD_CYC,
  parameter int unsigned START_CYC = plt_pkg::START_CYC,
  parameter int unsigned ZERO_CYC = plt_pkg::ZERO_CYC,
  parameter int unsigned ONE_CYC = plt_pkg::ONE_CYC,
  parameter int unsigned MIN_CYC = plt_pkg::MIN_CYC,
  parameter int unsigned MID_CYC = plt_pkg::MID_CYC,
  parameter int unsigned MAX_CYC = plt_pkg::MAX_CYC,
  parameter int unsigned IDLE_CYC = plt_pkg::IDLE_CYC,
  parameter int unsigned ENA_CYC = plt_pkg::ENA_CYC,
  parameter int unsigned GAP_CYC = plt_pkg::GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic level_req_in,
  input wire logic level_req_shorted,
  input wire logic limit_enable_strap,
  input wire logic switch_enhanced,
  input wire logic limit_reached,
  input wire logic mark_event_seen,
  input wire logic wall_adapter_sense,
  input wire logic [7:0] class_level,
  input wire logic [7:0] input_power,
  output logic event_indicator_output,
  output logic limit_sink_output,
  output logic limit_mode_current,
  output logic limit_enabled,
  output logic [7:0] limit_reference,
  output logic isolation_switch_off,
  output logic class_current_off,
  output logic mps_comparator_off
);
  localparam int CW = plt_pkg::CNT_W;
  localparam logic [CW-1:0] PERIOD_C = CW'(PERIOD_CYC);
  localparam logic [CW-1:0] START_C = CW'(START_CYC);
  localparam logic [CW-1:0] ZERO_C = CW'(ZERO_CYC);
  localparam logic [CW-1:0] ONE_C = CW'(ONE_CYC);
  localparam logic [CW-1:0] ENA_C = CW'(ENA_CYC);
  localparam logic [CW-1:0] GAP_C = CW'(GAP_CYC);

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == plt_pkg::REG_CTRL) || (a == plt_pkg::REG_STATUS) ||
               (a == plt_pkg::REG_FRAMES);
  endfunction : addr_hit

  // -----------------------------------------------------------------------
  // Symbol capture
  // -----------------------------------------------------------------------
  plt_pkg::plt_sym_t sym;

  plt_pulse_meter #(
    .MIN_CYC(MIN_CYC),
    .MID_CYC(MID_CYC),
    .MAX_CYC(MAX_CYC),
    .IDLE_CYC(IDLE_CYC)
  ) u_meter (
    .clk(clk),
    .rst_n(rst_n),
    .pin(level_req_in),
    .sym(sym)
  );

  // -----------------------------------------------------------------------
  // Frame assembly and mode/level selection
  // -----------------------------------------------------------------------
  typedef enum logic {
    FR_RUN,
    FR_DROP
  } plt_frame_t;

  plt_frame_t fr_r, fr_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [9:0] sh, sh_r, sh_nxt;
  logic [7:0] req_r, req_nxt;
  logic [7:0] frames_r, frames_nxt;
  logic has_req_r, has_req_nxt;
  logic has_mode_r, has_mode_nxt;
  plt_pkg::plt_mode_t req_mode_r, req_mode_nxt, target;
  plt_pkg::plt_mode_t mode_r, mode_nxt;
  logic loop_active_r;

  always_comb begin
    fr_nxt = fr_r;
    idx_nxt = idx_r;
    sh_nxt = sh_r;
    req_nxt = req_r;
    frames_nxt = frames_r;
    has_req_nxt = has_req_r;
    has_mode_nxt = has_mode_r;
    req_mode_nxt = req_mode_r;
    sh = {sh_r[8:0], sym.one};
    if (sym.idle) begin
      // A quiet line ends any partial frame
      fr_nxt = FR_RUN;
      idx_nxt = '0;
    end else if (fr_r == FR_RUN && sym.bad) begin
      fr_nxt = FR_DROP;
      idx_nxt = '0;
    end else if (fr_r == FR_RUN && sym.valid) begin
      sh_nxt = sh;
      if (idx_r == plt_pkg::FRAME_LAST) begin
        idx_nxt = '0;
        if (sh[9:8] == plt_pkg::SIG_POWER ||
            sh[9:8] == plt_pkg::SIG_CURRENT) begin
          req_nxt = sh[7:0];
          has_req_nxt = 1'b1;
          has_mode_nxt = 1'b1;
          frames_nxt = frames_r + 1'b1;
          req_mode_nxt = (sh[9:8] == plt_pkg::SIG_POWER) ?
                         plt_pkg::PLT_MODE_POWER :
                         plt_pkg::PLT_MODE_CURRENT;
        end
      end else begin
        idx_nxt = idx_r + 1'b1;
      end
    end
  end

  always_comb begin
    // Strap level only matters until a frame names the mode
    if (has_mode_r) begin
      target = req_mode_r;
    end else if (level_req_shorted) begin
      target = plt_pkg::PLT_MODE_CURRENT;
    end else begin
      target = plt_pkg::PLT_MODE_POWER;
    end
    mode_nxt = loop_active_r ? mode_r : target;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= FR_RUN;
      idx_r <= '0;
      sh_r <= '0;
      req_r <= '0;
      frames_r <= '0;
      has_req_r <= 1'b0;
      has_mode_r <= 1'b0;
      req_mode_r <= plt_pkg::PLT_MODE_POWER;
      mode_r <= plt_pkg::PLT_MODE_POWER;
    end else begin
      fr_r <= fr_nxt;
      idx_r <= idx_nxt;
      sh_r <= sh_nxt;
      req_r <= req_nxt;
      frames_r <= frames_nxt;
      has_req_r <= has_req_nxt;
      has_mode_r <= has_mode_nxt;
      req_mode_r <= req_mode_nxt;
      mode_r <= mode_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Limit enable, reference and wall adapter
  // -----------------------------------------------------------------------
  logic [CW-1:0] ena_cnt_r, ena_cnt_nxt;
  logic lim_en_r, lim_en_nxt;
  logic mark_r, mark_nxt;
  logic wall_r, wall_nxt;
  logic [7:0] ref_r, ref_nxt;
  logic sink_r, sink_nxt;

  always_comb begin
    ena_cnt_nxt = ena_cnt_r;
    lim_en_nxt = lim_en_r;
    if (!switch_enhanced || !limit_enable_strap || wall_r) begin
      ena_cnt_nxt = '0;
      lim_en_nxt = 1'b0;
    end else if (!lim_en_r) begin
      if (ena_cnt_r == ENA_C - 1'b1) begin
        lim_en_nxt = 1'b1;
      end else begin
        ena_cnt_nxt = ena_cnt_r + 1'b1;
      end
    end
    mark_nxt = mark_r | mark_event_seen;
    wall_nxt = mark_r & wall_adapter_sense;
    ref_nxt = has_req_r ? req_r : class_level;
    sink_nxt = lim_en_r & limit_reached;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ena_cnt_r <= '0;
      lim_en_r <= 1'b0;
      mark_r <= 1'b0;
      wall_r <= 1'b0;
      ref_r <= '0;
      sink_r <= 1'b0;
      loop_active_r <= 1'b0;
    end else begin
      ena_cnt_r <= ena_cnt_nxt;
      lim_en_r <= lim_en_nxt;
      mark_r <= mark_nxt;
      wall_r <= wall_nxt;
      ref_r <= ref_nxt;
      sink_r <= sink_nxt;
      loop_active_r <= sink_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Telemetry transmitter
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TM_GAP,
    TM_HIGH,
    TM_LOW
  } plt_tele_t;

  plt_tele_t tm_r, tm_nxt;
  logic [CW-1:0] tcnt_r, tcnt_nxt, width;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] dat_r, dat_nxt;
  logic ind_r, ind_nxt;
  logic tele_en_r, tele_en_nxt;

  always_comb begin
    tm_nxt = tm_r;
    tcnt_nxt = tcnt_r + 1'b1;
    bit_nxt = bit_r;
    dat_nxt = dat_r;
    if (bit_r == '0) begin
      width = START_C;
    end else begin
      width = dat_r[7] ? ONE_C : ZERO_C;
    end
    case (tm_r)
      TM_GAP: begin
        // Wall adapter pattern owns the indicator pin
        if (!tele_en_r || wall_r) begin
          tcnt_nxt = '0;
        end else if (tcnt_r == GAP_C - 1'b1) begin
          tcnt_nxt = '0;
          bit_nxt = '0;
          dat_nxt = input_power;
          tm_nxt = TM_HIGH;
        end
      end
      TM_HIGH: begin
        if (tcnt_r == width - 1'b1) begin
          tm_nxt = TM_LOW;
        end
      end
      TM_LOW: begin
        if (tcnt_r == PERIOD_C - 1'b1) begin
          tcnt_nxt = '0;
          if (bit_r != '0) begin
            dat_nxt = {dat_r[6:0], 1'b0};
          end
          if (bit_r == plt_pkg::TELE_LAST) begin
            tm_nxt = TM_GAP;
          end else begin
            bit_nxt = bit_r + 1'b1;
            tm_nxt = TM_HIGH;
          end
        end
      end
      default: begin
        tm_nxt = TM_GAP;
        tcnt_nxt = '0;
      end
    endcase
    ind_nxt = (tm_nxt == TM_HIGH) | wall_nxt;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tm_r <= TM_GAP;
      tcnt_r <= '0;
      bit_r <= '0;
      dat_r <= '0;
      ind_r <= 1'b0;
    end else begin
      tm_r <= tm_nxt;
      tcnt_r <= tcnt_nxt;
      bit_r <= bit_nxt;
      dat_r <= dat_nxt;
      ind_r <= ind_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // APB slave
  // -----------------------------------------------------------------------
  // Read data is captured in the setup cycle so pready can stay high
  plt_pkg::plt_status_t stat;
  logic [31:0] rd_nxt, prdata_r;

  always_comb begin
    stat = '0;
    stat.wall = wall_r;
    stat.lim_en = lim_en_r;
    stat.from_req = has_req_r;
    stat.pend_cur = (target == plt_pkg::PLT_MODE_CURRENT);
    stat.mode_cur = (mode_r == plt_pkg::PLT_MODE_CURRENT);
    stat.req_level = req_r;
    stat.reference = ref_r;
    tele_en_nxt = tele_en_r;
    if (psel && penable && pwrite && pstrb[0] &&
        paddr == plt_pkg::REG_CTRL) begin
      tele_en_nxt = pwdata[plt_pkg::CTRL_TELE_EN_BIT];
    end
    rd_nxt = prdata_r;
    if (psel && !penable) begin
      rd_nxt = '0;
      if (!addr_hit(paddr)) begin
        rd_nxt = '0;
      end else if (paddr == plt_pkg::REG_CTRL) begin
        rd_nxt[plt_pkg::CTRL_TELE_EN_BIT] = tele_en_r;
      end else if (paddr == plt_pkg::REG_STATUS) begin
        rd_nxt = stat;
      end else begin
        rd_nxt = {24'h000000, frames_r};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tele_en_r <= plt_pkg::CTRL_TELE_EN_RST;
      prdata_r <= '0;
    end else begin
      tele_en_r <= tele_en_nxt;
      prdata_r <= rd_nxt;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign prdata = prdata_r;

  assign event_indicator_output = ind_r;
  assign limit_sink_output = sink_r;
  assign limit_mode_current = (mode_r == plt_pkg::PLT_MODE_CURRENT);
  assign limit_enabled = lim_en_r;
  assign limit_reference = ref_r;
  assign isolation_switch_off = wall_r;
  assign class_current_off = wall_r;
  assign mps_comparator_off = wall_r;

endmodule : plt_limit_telemetry

// ==== plt_mcu_model.sv ====
// Behavioural management controller driving the level-request pin
`timescale 1ns/100ps
module plt_mcu_model #(
  // Bench scale: one cycle stands for 25 us of line time
  parameter int unsigned PERIOD_CYC = plt_pkg::T_PERIOD_US / 25,
  parameter int unsigned ZERO_CYC = plt_pkg::T_ZERO_US / 25,
  parameter int unsigned ONE_CYC = plt_pkg::T_ONE_US / 25,
  // The 22 ms minimum spacing between frames, at bench scale
  parameter int unsigned GAP_CYC = 22000 / 25
) (
  input wire logic clk,
  output logic pin
);
  // ----------------------------------------------------------------------
  // Frame sender: signature pair then level, first symbol first
  // ----------------------------------------------------------------------
  initial pin = 1'b0;
  // Runt index corrupts one symbol on purpose; -1 sends a clean frame
  task automatic send(input logic [9:0] syms, input int runt);
    int w;
    for (int i = 9; i >= 0; i--) begin
      w = syms[i] ? ONE_CYC : ZERO_CYC;
      if (9 - i == runt) w = 3;
      for (int t = 0; t < PERIOD_CYC; t++) begin
        @(posedge clk);
        pin <= (t < w);
      end
    end
    repeat (GAP_CYC) @(posedge clk);
  endtask : send
endmodule : plt_mcu_model

// ==== plt_monitor.sv ====
// Assertion checker for the limit configuration and telemetry block
`timescale 1ns/100ps
module plt_monitor #(
  parameter int unsigned START_CYC = 36,
  parameter int unsigned ZERO_CYC = 20,
  parameter int unsigned ONE_CYC = 30,
  parameter int unsigned ENA_CYC = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic limit_enable_strap,
  input wire logic switch_enhanced,
  input wire logic limit_reached,
  input wire logic mark_event_seen,
  input wire logic wall_adapter_sense,
  input wire logic event_indicator_output,
  input wire logic limit_sink_output,
  input wire logic limit_mode_current,
  input wire logic limit_enabled,
  input wire logic isolation_switch_off,
  input wire logic class_current_off,
  input wire logic mps_comparator_off
);
  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic mark_r;
  logic mark_nxt;
  logic [15:0] en_cnt_r;
  logic [15:0] en_cnt_nxt;
  logic [15:0] hi_cnt_r;
  logic [15:0] hi_cnt_nxt;
  always_comb begin
    mark_nxt = mark_r | mark_event_seen;
    en_cnt_nxt = 16'h0;
    if (switch_enhanced && limit_enable_strap && en_cnt_r != 16'hFFFF) begin
      en_cnt_nxt = en_cnt_r + 16'h1;
    end
    hi_cnt_nxt = event_indicator_output ? hi_cnt_r + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mark_r <= 1'b0;
      en_cnt_r <= 16'h0;
      hi_cnt_r <= 16'h0;
    end else begin
      mark_r <= mark_nxt;
      en_cnt_r <= en_cnt_nxt;
      hi_cnt_r <= hi_cnt_nxt;
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wall_on;
    mark_r && wall_adapter_sense;
  endsequence
  sequence s_wall_out;
    isolation_switch_off && class_current_off && mps_comparator_off
      && event_indicator_output;
  endsequence
  AST_WALL_REACTION: assert property (
    s_wall_on |-> ##[1:3] s_wall_out)
    else $error("wall adapter reaction missing");
  AST_WALL_ARMED: assert property (
    isolation_switch_off |-> mark_r)
    else $error("wall reaction before mark event");
  AST_STRAP_OPEN: assert property (
    !limit_enable_strap ##1 !limit_enable_strap |-> !limit_enabled)
    else $error("limiting on with strap open");
  AST_ENA_DELAY: assert property (
    $rose(limit_enabled) |-> en_cnt_r >= ENA_CYC - 2
      && en_cnt_r <= ENA_CYC + 2)
    else $error("limit enable delay wrong");
  AST_ENA_STAYS: assert property (
    limit_enabled && limit_enable_strap && switch_enhanced
      && !wall_adapter_sense |=> limit_enabled)
    else $error("limit enable dropped");
  AST_SINK_GATED: assert property (
    $rose(limit_sink_output) |-> $past(limit_enabled && limit_reached))
    else $error("sink active without enabled limit");
  AST_MODE_QUIET: assert property (
    $changed(limit_mode_current) |-> !$past(limit_sink_output))
    else $error("mode changed while regulating");
  AST_PULSE_WIDTH: assert property (
    $fell(event_indicator_output) && !isolation_switch_off
      |-> hi_cnt_r == START_CYC || hi_cnt_r == ZERO_CYC
      || hi_cnt_r == ONE_CYC)
    else $error("indicator pulse width wrong");
endmodule : plt_monitor

bind plt_limit_telemetry plt_monitor #(.START_CYC(START_CYC),
  .ZERO_CYC(ZERO_CYC), .ONE_CYC(ONE_CYC), .ENA_CYC(ENA_CYC)) u_mon (
  .clk(clk), .rst_n(rst_n), .limit_enable_strap(limit_enable_strap),
  .switch_enhanced(switch_enhanced), .limit_reached(limit_reached),
  .mark_event_seen(mark_event_seen),
  .wall_adapter_sense(wall_adapter_sense),
  .event_indicator_output(event_indicator_output),
  .limit_sink_output(limit_sink_output),
  .limit_mode_current(limit_mode_current),
  .limit_enabled(limit_enabled),
  .isolation_switch_off(isolation_switch_off),
  .class_current_off(class_current_off),
  .mps_comparator_off(mps_comparator_off));

// ==== plt_pkg.sv ====
// Shared constants and types for the limit configuration and telemetry block
package plt_pkg;

  // ----------------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 22;

  // ----------------------------------------------------------------------
  // Symbol timing, microseconds and derived cycles
  // ----------------------------------------------------------------------
  localparam int T_PERIOD_US = 1000;
  localparam int T_START_US = 900;
  localparam int T_ZERO_US = 500;
  localparam int T_ONE_US = 750;
  localparam int T_MID_US = 625;
  localparam int T_MIN_US = 250;
  localparam int T_MAX_US = 875;
  localparam int T_IDLE_US = 1500;
  localparam int T_ENA_US = 1200;
  localparam int T_GAP_US = 10000;

  localparam int PERIOD_CYC = T_PERIOD_US * CLK_MHZ;
  localparam int START_CYC = T_START_US * CLK_MHZ;
  localparam int ZERO_CYC = T_ZERO_US * CLK_MHZ;
  localparam int ONE_CYC = T_ONE_US * CLK_MHZ;
  localparam int MID_CYC = T_MID_US * CLK_MHZ;
  localparam int MIN_CYC = T_MIN_US * CLK_MHZ;
  localparam int MAX_CYC = T_MAX_US * CLK_MHZ;
  localparam int IDLE_CYC = T_IDLE_US * CLK_MHZ;
  localparam int ENA_CYC = T_ENA_US * CLK_MHZ;
  localparam int GAP_CYC = T_GAP_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------------
  localparam logic [3:0] FRAME_LAST = 4'h9;
  localparam logic [3:0] TELE_LAST = 4'h8;
  localparam logic [1:0] SIG_POWER = 2'h1;
  localparam logic [1:0] SIG_CURRENT = 2'h2;

  // ----------------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FRAMES = 12'h008;
  localparam int CTRL_TELE_EN_BIT = 0;
  localparam logic CTRL_TELE_EN_RST = 1'b1;

  typedef enum logic {
    PLT_MODE_POWER,
    PLT_MODE_CURRENT
  } plt_mode_t;

  typedef struct packed {
    logic valid;
    logic one;
    logic bad;
    logic idle;
  } plt_sym_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic wall;
    logic lim_en;
    logic from_req;
    logic pend_cur;
    logic mode_cur;
    logic [7:0] req_level;
    logic [7:0] reference;
  } plt_status_t;

endpackage : plt_pkg

// ==== plt_pulse_meter.sv ====
// High-time meter that turns the level-request pin into symbols
`timescale 1ns/100ps
module plt_pulse_meter #(
  parameter int unsigned MIN_CYC = plt_pkg::MIN_CYC,
  parameter int unsigned MID_CYC = plt_pkg::MID_CYC,
  parameter int unsigned MAX_CYC = plt_pkg::MAX_CYC,
  parameter int unsigned IDLE_CYC = plt_pkg::IDLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output plt_pkg::plt_sym_t sym
);
  localparam logic [plt_pkg::CNT_W-1:0] MIN_C = plt_pkg::CNT_W'(MIN_CYC);
  localparam logic [plt_pkg::CNT_W-1:0] MID_C = plt_pkg::CNT_W'(MID_CYC);
  localparam logic [plt_pkg::CNT_W-1:0] MAX_C = plt_pkg::CNT_W'(MAX_CYC);
  localparam logic [plt_pkg::CNT_W-1:0] IDLE_C = plt_pkg::CNT_W'(IDLE_CYC);

  logic pin_r;
  logic over_r, over_nxt;
  logic [plt_pkg::CNT_W-1:0] hi_r, hi_nxt, lo_r, lo_nxt;
  plt_pkg::plt_sym_t sym_r, sym_nxt;

  always_comb begin
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    over_nxt = over_r;
    sym_nxt = '0;
    if (pin) begin
      hi_nxt = hi_r + 1'b1;
      lo_nxt = '0;
      // A stuck-high pin is reported once, not as a symbol
      if (hi_r == MAX_C && !over_r) begin
        sym_nxt.bad = 1'b1;
        over_nxt = 1'b1;
      end
      if (over_r) begin
        hi_nxt = hi_r;
      end
    end else begin
      if (pin_r && !over_r) begin
        sym_nxt.valid = 1'b1;
        sym_nxt.one = (hi_r >= MID_C);
        sym_nxt.bad = (hi_r < MIN_C);
      end
      hi_nxt = '0;
      over_nxt = 1'b0;
      if (lo_r != IDLE_C) begin
        lo_nxt = lo_r + 1'b1;
      end
      if (lo_r == IDLE_C - 1'b1) begin
        sym_nxt.idle = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 1'b0;
      over_r <= 1'b0;
      hi_r <= '0;
      lo_r <= '0;
      sym_r <= '0;
    end else begin
      pin_r <= pin;
      over_r <= over_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      sym_r <= sym_nxt;
    end
  end

  assign sym = sym_r;

endmodule : plt_pulse_meter

// ==== tb_top.sv ====
// Self-checking bench for the limit configuration and telemetry block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic req, shorted, strap, sw_on, at_lim, mark, wall;
  logic ind, sink, mode_cur, lim_en, iso_off, cls_off, mps_off;
  logic [7:0] cls, pwr, ref_o;
  logic [3:0] strb;
  int n_fail = 0;
  int comparisons = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Bench scale: one cycle stands for 25 us, so every ratio is kept
  localparam int unsigned SC = 25;
  plt_limit_telemetry #(.PERIOD_CYC(plt_pkg::T_PERIOD_US / SC),
    .START_CYC(plt_pkg::T_START_US / SC),
    .ZERO_CYC(plt_pkg::T_ZERO_US / SC), .ONE_CYC(plt_pkg::T_ONE_US / SC),
    .MIN_CYC(plt_pkg::T_MIN_US / SC), .MID_CYC(plt_pkg::T_MID_US / SC),
    .MAX_CYC(plt_pkg::T_MAX_US / SC), .IDLE_CYC(plt_pkg::T_IDLE_US / SC),
    .ENA_CYC(plt_pkg::T_ENA_US / SC),
    .GAP_CYC(plt_pkg::T_GAP_US / SC)) DUT (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(strb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .level_req_in(req), .level_req_shorted(shorted),
    .limit_enable_strap(strap), .switch_enhanced(sw_on),
    .limit_reached(at_lim), .mark_event_seen(mark),
    .wall_adapter_sense(wall), .class_level(cls), .input_power(pwr),
    .event_indicator_output(ind), .limit_sink_output(sink),
    .limit_mode_current(mode_cur), .limit_enabled(lim_en),
    .limit_reference(ref_o), .isolation_switch_off(iso_off),
    .class_current_off(cls_off), .mps_comparator_off(mps_off));
  plt_mcu_model MCU (.clk(clk), .pin(req));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task tally_and_finish;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin n_fail++; tally_and_finish; end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic pulse(output int hi);
    int n = 0;
    hi = 0;
    while (ind !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
    while (ind === 1'b1 && hi < 100) begin @(posedge clk); hi++; end
    if (n >= 2000 || hi >= 100) begin n_fail++; tally_and_finish; end
  endtask : pulse
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_defaults;
    `CHK("ref", cls, ref_o)
    `CHK("mode", 1'b0, mode_cur)
    apb(1'b0, 12'h000, 32'h0); `CHK("ctrl", 32'h1, rd)
    apb(1'b0, 12'h004, 32'h0); `CHK("status", {24'h0, cls}, rd)
    apb(1'b0, 12'h0FC, 32'h0); `CHK("unmapped", 1'b1, err)
    `CHK("unmapped rd", 32'h0, rd)
    apb(1'b1, 12'h000, 32'h0); apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl off", 32'h0, rd)
    apb(1'b1, 12'h000, 32'h1);
    // Lane 0 strobe low: the enable bit must survive the write
    strb <= 4'hE;
    apb(1'b1, 12'h000, 32'h0);
    strb <= 4'hF;
    apb(1'b0, 12'h000, 32'h0);
    `CHK("ctrl strobe", 32'h1, rd)
  endtask : t_defaults
  task t_shorted;
    shorted <= 1'b1; repeat (4) @(posedge clk);
    `CHK("mode", 1'b1, mode_cur)
    shorted <= 1'b0; repeat (4) @(posedge clk);
    `CHK("mode", 1'b0, mode_cur)
  endtask : t_shorted
  task t_frames;
    MCU.send({2'b01, 8'hA5}, -1);
    `CHK("ref", 8'hA5, ref_o)
    `CHK("mode", 1'b0, mode_cur)
    MCU.send({2'b10, 8'h3C}, -1);
    `CHK("ref", 8'h3C, ref_o)
    `CHK("mode", 1'b1, mode_cur)
    MCU.send({2'b01, 8'h77}, 4);
    MCU.send({2'b00, 8'h11}, -1);
    `CHK("ref", 8'h3C, ref_o)
    apb(1'b0, 12'h008, 32'h0); `CHK("frames", 32'h2, rd)
  endtask : t_frames
  task t_enable;
    strap <= 1'b0; sw_on <= 1'b1; repeat (60) @(posedge clk);
    `CHK("lim_en", 1'b0, lim_en)
    strap <= 1'b1; repeat (40) @(posedge clk);
    `CHK("lim_en", 1'b0, lim_en)
    repeat (16) @(posedge clk);
    `CHK("lim_en", 1'b1, lim_en)
  endtask : t_enable
  task t_mode_hold;
    at_lim <= 1'b1; repeat (3) @(posedge clk);
    `CHK("sink", 1'b1, sink)
    MCU.send({2'b01, 8'h5A}, -1);
    `CHK("ref", 8'h5A, ref_o)
    `CHK("mode", 1'b1, mode_cur)
    at_lim <= 1'b0; repeat (4) @(posedge clk);
    `CHK("mode", 1'b0, mode_cur)
  endtask : t_mode_hold
  task automatic t_telemetry;
    int hi = 0;
    int n = 0;
    while (hi < 33 && n < 20) begin pulse(hi); n++; end
    `CHK("start", plt_pkg::T_START_US / SC, hi)
    for (int b = 7; b >= 0; b--) begin
      pulse(hi);
      `CHK("bit", pwr[b] ? plt_pkg::T_ONE_US / SC : plt_pkg::T_ZERO_US / SC, hi)
    end
  endtask : t_telemetry
  task t_wall;
    wall <= 1'b1; repeat (6) @(posedge clk);
    `CHK("iso_off", 1'b0, iso_off)
    mark <= 1'b1; repeat (6) @(posedge clk);
    `CHK("wall", 4'hF, {iso_off, cls_off, mps_off, ind})
  endtask : t_wall
  task t_power_cycle;
    // New class level proves the reference follows it, not a stale copy
    cls <= 8'h61;
    rst_n <= 1'b0; repeat (5) @(posedge clk);
    mark <= 1'b0; wall <= 1'b0; rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("ref", cls, ref_o)
    `CHK("mode", 1'b0, mode_cur)
  endtask : t_power_cycle
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; shorted = 1'b0; strap = 1'b1;
    sw_on = 1'b0; at_lim = 1'b0; mark = 1'b0; wall = 1'b0;
    cls = 8'h2D; pwr = 8'hB4;
    strb = 4'hF;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_defaults;
    t_shorted;
    t_frames;
    t_enable;
    t_mode_hold;
    t_telemetry;
    t_wall;
    t_power_cycle;
    tally_and_finish;
  end
endmodule : tb_top
